// ===== sqr_pkg.sv
package sqr_pkg;
  // opcodes
  localparam logic [7:0] OP_SW_CMD   = 8'h25;
  localparam logic [7:0] OP_IN_CMD   = 8'h27;
  localparam logic [7:0] OP_TMP_CMD  = 8'h33;
  localparam logic [7:0] OP_GRP_CMD  = 8'h35;
  localparam logic [7:0] OP_RSP_INC  = 8'h01;
  localparam logic [1:0] RW_READ     = 2'h0;
  // execution status codes
  localparam logic [5:0] ST_OK       = 6'h00;
  localparam logic [5:0] ST_NO_WRITE = 6'h03;
  localparam logic [5:0] ST_BAD_ELEM = 6'h07;
  localparam logic [5:0] ST_NO_CHAN  = 6'h08;
  localparam logic [5:0] ST_NO_GRP   = 6'h09;
  localparam logic [5:0] ST_NO_OP    = 6'h3e;
  // element selectors
  localparam logic [7:0] EL_GRP_BASE = 8'h64;
  localparam logic [7:0] EL_GRP_LAST = 8'h95;
  localparam logic [7:0] EL_INPUT    = 8'hbe;
  localparam logic [7:0] EL_TEMP     = 8'h98;
  localparam logic [7:0] GRP_NONE    = 8'hfb;
  // measurement code zero points and ratios (tenths)
  localparam logic [23:0] I_ZERO     = 24'h7a1200;
  localparam logic [15:0] V_ZERO     = 16'h7d78;
  localparam logic [31:0] RATIO_DEN  = 32'h0000000a;
  localparam logic [31:0] VHIGH_NUM  = 32'h00000006;
  localparam logic [31:0] IHIGH_NUM  = 32'h00000003;
  localparam logic [31:0] SHARE_NUM  = 32'h00000001;
  // register byte offsets
  localparam logic [4:0] REG_CMD     = 5'h00;
  localparam logic [4:0] REG_CTRL    = 5'h04;
  localparam logic [4:0] REG_RSP_HDR = 5'h08;
  localparam logic [4:0] REG_RSP_HI  = 5'h0c;
  localparam logic [4:0] REG_RSP_LO  = 5'h10;
  // register field positions
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_RW_LSB  = 8;
  localparam int CMD_EL_LSB  = 16;
  localparam int CTRL_GO     = 0;
  localparam int CTRL_DONE   = 1;
  localparam int HDR_ST_LSB  = 8;
  localparam int HDR_RW_LSB  = 14;
  localparam int HDR_EL_LSB  = 16;
  // channel record layout in the snapshot memory
  localparam int MW_GRP_LSB  = 0;
  localparam int MW_BAT      = 8;
  localparam int MW_TRIP     = 9;
  localparam int MW_CMD      = 10;
  localparam int MW_SW       = 11;
  localparam int MW_THR_LSB  = 12;
  localparam int MW_OI_LSB   = 36;
  localparam int MW_OV_LSB   = 60;
  localparam int MEM_W       = 76;
  localparam int DATA_W      = 48;
  localparam int GRP_FIELDS  = 8;

  // current magnitude in 10 mA steps
  function automatic logic [23:0] cur_mag(input logic [23:0] code);
    return (code > I_ZERO) ? code - I_ZERO : 24'h000000;
  endfunction

  // voltage magnitude in 50 mV steps
  function automatic logic [23:0] volt_mag(input logic [15:0] code);
    return (code > V_ZERO) ? {8'h00, code - V_ZERO} : 24'h000000;
  endfunction

  // a above num tenths of b
  function automatic logic exceeds(input logic [23:0] a, input logic [23:0] b,
                                   input logic [31:0] num);
    return (32'(a) * RATIO_DEN) > (32'(b) * num);
  endfunction

  // one flag as a two-bit field
  function automatic logic [1:0] fld2(input logic b);
    return {1'b0, b};
  endfunction
endpackage

// ===== sqr_chan_mem.sv
`timescale 1ns/10ps
module sqr_chan_mem #(
  parameter int W     = 76,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata_q
);
  logic [W-1:0] mem [DEPTH];

  // write port, fed by the measurement side
  always_ff @(posedge clk_sys) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (ce) begin
      rdata_q <= mem[raddr];
    end
  end
endmodule // sqr_chan_mem

// ===== sqr_top.sv
`timescale 1ns/10ps
module sqr_top import sqr_pkg::*; #(
  parameter int NUM_CH = 8,
  parameter int CH_W   = $clog2(NUM_CH)
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              meas_we,
  input  wire logic [CH_W-1:0]   meas_chan,
  input  wire logic [15:0]       meas_out_volt,
  input  wire logic [23:0]       meas_out_cur,
  input  wire logic [23:0]       meas_ovl_thr,
  input  wire logic              meas_sw_on,
  input  wire logic              meas_cmd_on,
  input  wire logic              meas_trip,
  input  wire logic              meas_battle,
  input  wire logic [7:0]        meas_group,
  input  wire logic [23:0]       in_cur_code,
  input  wire logic [15:0]       in_volt_code,
  input  wire logic [15:0]       temp_code
);
  localparam int MASK_W = (NUM_CH > GRP_FIELDS) ? NUM_CH : GRP_FIELDS;

  typedef enum logic [2:0] {
    S_IDLE,
    S_TGT_A,
    S_TGT_D,
    S_SCAN_A,
    S_SCAN_D,
    S_DONE
  } sqr_state_t;

  sqr_state_t        state_q;
  logic [7:0]        cmd_op_q;
  logic [1:0]        cmd_rw_q;
  logic [7:0]        cmd_el_q;
  logic              done_q;
  logic [7:0]        rsp_op_q;
  logic [5:0]        rsp_st_q;
  logic [1:0]        rsp_rw_q;
  logic [7:0]        rsp_el_q;
  logic [DATA_W-1:0] rsp_data_q;
  logic [5:0]        pend_st_q;
  logic [CH_W-1:0]   idx_q;
  logic [7:0]        grp_q;
  logic              grp_path_q;
  logic [MEM_W-1:0]  tgt_q;
  logic              have_tgt_q;
  logic [MASK_W-1:0] mask_q;
  logic [23:0]       imax_q;
  logic [23:0]       imin_q;
  logic              rd_ack_q;
  logic [MEM_W-1:0]  mem_rdata;
  logic [MEM_W-1:0]  meas_word;
  logic              busy;
  logic              wr_take;
  logic              rd_take;
  logic              go;
  logic              is_chan_el;
  logic              is_grp_el;
  logic              member;
  logic [23:0]       scan_imag;
  logic              flag_vhigh;
  logic              flag_ihigh;
  logic              flag_bit;
  logic              flag_share;
  logic              should_on;
  logic [15:0]       memb_bits;
  logic [DATA_W-1:0] rsp_data_d;
  logic [5:0]        rsp_st_d;

  assign busy = (state_q != S_IDLE);

  // bus handshake: reads take one wait cycle, command writes stall while busy
  always_comb begin
    avs_waitrequest = 1'b0;
    if (!ce) begin
      avs_waitrequest = avs_read | avs_write;
    end else if (avs_read && !rd_ack_q) begin
      avs_waitrequest = 1'b1;
    end else if (avs_write && busy &&
                 (avs_address == REG_CMD || avs_address == REG_CTRL)) begin
      avs_waitrequest = 1'b1;
    end
  end

  assign wr_take = avs_write & ~avs_waitrequest;
  assign rd_take = avs_read & ce & ~rd_ack_q;
  assign go      = wr_take && avs_address == REG_CTRL && avs_byteenable[0] &&
                   avs_writedata[CTRL_GO];

  // read data register and its one-cycle acknowledge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_ack_q     <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else if (ce) begin
      rd_ack_q <= rd_take;
      if (rd_take) begin
        unique case (avs_address)
          REG_CMD:     avs_readdata <= {8'h00, cmd_el_q, 6'h00, cmd_rw_q, cmd_op_q};
          REG_CTRL:    avs_readdata <= {30'h00000000, done_q, busy};
          REG_RSP_HDR: avs_readdata <= {8'h00, rsp_el_q, rsp_rw_q, rsp_st_q, rsp_op_q};
          REG_RSP_HI:  avs_readdata <= rsp_data_q[DATA_W-1 -: 32];
          REG_RSP_LO:  avs_readdata <= {rsp_data_q[15:0], 16'h0000};
          default:     avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // command word, byte lanes honoured
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_op_q <= 8'h00;
      cmd_rw_q <= 2'h0;
      cmd_el_q <= 8'h00;
    end else if (wr_take && avs_address == REG_CMD) begin
      if (avs_byteenable[0]) begin
        cmd_op_q <= avs_writedata[CMD_OP_LSB +: 8];
      end
      if (avs_byteenable[1]) begin
        cmd_rw_q <= avs_writedata[CMD_RW_LSB +: 2];
      end
      if (avs_byteenable[2]) begin
        cmd_el_q <= avs_writedata[CMD_EL_LSB +: 8];
      end
    end
  end

  // done flag: completion sets, write-one clears, set wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (ce) begin
      if (state_q == S_DONE) begin
        done_q <= 1'b1;
      end else if (go || (wr_take && avs_address == REG_CTRL &&
                          avs_byteenable[0] && avs_writedata[CTRL_DONE])) begin
        done_q <= 1'b0;
      end
    end
  end

  // channel snapshot memory
  assign meas_word = {meas_out_volt, meas_out_cur, meas_ovl_thr, meas_sw_on,
                      meas_cmd_on, meas_trip, meas_battle, meas_group};

  sqr_chan_mem #(
    .W     (MEM_W),
    .DEPTH (NUM_CH),
    .AW    (CH_W)
  ) u_mem (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .we      (meas_we && (32'(meas_chan) < NUM_CH)),
    .waddr   (meas_chan),
    .wdata   (meas_word),
    .raddr   (idx_q),
    .rdata_q (mem_rdata)
  );

  // element classes
  assign is_chan_el = (cmd_el_q < EL_GRP_BASE);
  assign is_grp_el  = (cmd_el_q >= EL_GRP_BASE) && (cmd_el_q <= EL_GRP_LAST);

  // scan record belongs to the group of interest
  assign member    = (mem_rdata[MW_GRP_LSB +: 8] == grp_q) && (grp_q != GRP_NONE);
  assign scan_imag = cur_mag(mem_rdata[MW_OI_LSB +: 24]);

  // sequencer: decode, fetch target, scan all channels, answer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q    <= S_IDLE;
      pend_st_q  <= ST_OK;
      idx_q      <= '0;
      grp_q      <= GRP_NONE;
      grp_path_q <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        S_IDLE: begin
          if (go) begin
            pend_st_q  <= ST_OK;
            idx_q      <= '0;
            grp_path_q <= 1'b0;
            state_q    <= S_DONE;
            if (cmd_op_q != OP_SW_CMD && cmd_op_q != OP_IN_CMD &&
                cmd_op_q != OP_TMP_CMD && cmd_op_q != OP_GRP_CMD) begin
              pend_st_q <= ST_NO_OP;
            end else if (cmd_rw_q != RW_READ) begin
              pend_st_q <= ST_NO_WRITE;
            end else if (cmd_op_q == OP_IN_CMD) begin
              if (cmd_el_q != EL_INPUT) begin
                pend_st_q <= ST_BAD_ELEM;
              end
            end else if (cmd_op_q == OP_TMP_CMD) begin
              if (cmd_el_q != EL_TEMP) begin
                pend_st_q <= ST_BAD_ELEM;
              end
            end else if (is_grp_el) begin
              grp_q      <= cmd_el_q - EL_GRP_BASE;
              grp_path_q <= 1'b1;
              state_q    <= S_SCAN_A;
            end else if (cmd_op_q == OP_GRP_CMD) begin
              pend_st_q <= ST_BAD_ELEM;
            end else if (is_chan_el && (32'(cmd_el_q) < NUM_CH)) begin
              idx_q   <= cmd_el_q[CH_W-1:0];
              state_q <= S_TGT_A;
            end else if (is_chan_el) begin
              pend_st_q <= ST_NO_CHAN;
            end else begin
              pend_st_q <= ST_BAD_ELEM;
            end
          end
        end
        S_TGT_A: state_q <= S_TGT_D;
        S_TGT_D: begin
          grp_q   <= mem_rdata[MW_GRP_LSB +: 8];
          idx_q   <= '0;
          state_q <= S_SCAN_A;
        end
        S_SCAN_A: state_q <= S_SCAN_D;
        S_SCAN_D: begin
          if (32'(idx_q) == NUM_CH - 1) begin
            state_q <= S_DONE;
          end else begin
            idx_q   <= idx_q + CH_W'(1);
            state_q <= S_SCAN_A;
          end
        end
        S_DONE: state_q <= S_IDLE;
      endcase
    end
  end

  // target record, group membership and current spread
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tgt_q      <= '0;
      have_tgt_q <= 1'b0;
      mask_q     <= '0;
      imax_q     <= 24'h000000;
      imin_q     <= 24'hffffff;
    end else if (ce) begin
      if (state_q == S_IDLE && go) begin
        have_tgt_q <= 1'b0;
        mask_q     <= '0;
        imax_q     <= 24'h000000;
        imin_q     <= 24'hffffff;
      end else if (state_q == S_TGT_D) begin
        tgt_q      <= mem_rdata;
        have_tgt_q <= 1'b1;
      end else if (state_q == S_SCAN_D && member) begin
        mask_q[idx_q] <= 1'b1;
        if (scan_imag > imax_q) begin
          imax_q <= scan_imag;
        end
        if (scan_imag < imin_q) begin
          imin_q <= scan_imag;
        end
        if (!have_tgt_q) begin
          tgt_q      <= mem_rdata;
          have_tgt_q <= 1'b1;
        end
      end
    end
  end

  // switch status flags from the target record and the group scan
  assign flag_vhigh = exceeds(volt_mag(tgt_q[MW_OV_LSB +: 16]),
                              volt_mag(in_volt_code), VHIGH_NUM);
  assign flag_ihigh = exceeds(cur_mag(tgt_q[MW_OI_LSB +: 24]),
                              cur_mag(tgt_q[MW_THR_LSB +: 24]), IHIGH_NUM);
  assign should_on  = tgt_q[MW_CMD] & ~tgt_q[MW_TRIP];
  assign flag_bit   = should_on ? ~flag_vhigh : (flag_vhigh | flag_ihigh);
  assign flag_share = (grp_q != GRP_NONE) && (|mask_q) &&
                      exceeds(imax_q - imin_q, imax_q, SHARE_NUM);

  // membership fields, channel 0 first
  always_comb begin
    memb_bits = 16'h0000;
    for (int i = 0; i < GRP_FIELDS; i++) begin
      memb_bits[15 - 2*i -: 2] = fld2(mask_q[i]);
    end
  end

  // reply data area, left justified, unused bytes zero
  always_comb begin
    rsp_data_d = '0;
    rsp_st_d   = pend_st_q;
    if (pend_st_q == ST_OK) begin
      unique case (cmd_op_q)
        OP_SW_CMD: begin
          if (grp_path_q && !(|mask_q)) begin
            rsp_st_d = ST_NO_GRP;
          end else begin
            rsp_data_d = {fld2(tgt_q[MW_SW]), fld2(tgt_q[MW_CMD]),
                          fld2(flag_vhigh), fld2(flag_ihigh),
                          fld2(tgt_q[MW_TRIP]),
                          fld2(flag_bit),
                          fld2(tgt_q[MW_BAT]),
                          tgt_q[MW_GRP_LSB +: 8],
                          8'h00, 6'h00, fld2(flag_share), 10'h000};
          end
        end
        OP_IN_CMD:  rsp_data_d = {in_cur_code, in_volt_code, 8'h00};
        OP_TMP_CMD: rsp_data_d = {temp_code, 32'h00000000};
        OP_GRP_CMD: begin
          if (!(|mask_q)) begin
            rsp_st_d = ST_NO_GRP;
          end else begin
            rsp_data_d = {8'h00, memb_bits, 24'h000000};
          end
        end
        default: rsp_data_d = '0;
      endcase
    end
  end

  // reply registers, loaded once per query
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp_op_q   <= 8'h00;
      rsp_st_q   <= ST_OK;
      rsp_rw_q   <= 2'h0;
      rsp_el_q   <= 8'h00;
      rsp_data_q <= '0;
    end else if (ce && state_q == S_DONE) begin
      rsp_op_q   <= cmd_op_q + OP_RSP_INC;
      rsp_st_q   <= rsp_st_d;
      rsp_rw_q   <= cmd_rw_q;
      rsp_el_q   <= cmd_el_q;
      rsp_data_q <= rsp_data_d;
    end
  end
endmodule // sqr_top

// ===== sqr_top_monitor.sv
`timescale 1ns/10ps
module sqr_top_monitor import sqr_pkg::*; (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [23:0] in_cur_code,
  input wire logic [15:0] in_volt_code,
  input wire logic [15:0] temp_code
);
  logic [7:0] cmd_op_q, cmd_el_q, go_op_q, go_el_q;
  logic [1:0] cmd_rw_q, go_rw_q;
  logic       wr_ok, rd_ok, hdr_rd, hi_rd, lo_rd, known_op, refused, temp_ok, in_ok;
  // completed transfers and the query that the last go started
  assign wr_ok = avs_write && ce && !avs_waitrequest;
  assign rd_ok = avs_read && ce && !avs_waitrequest;
  assign hdr_rd = rd_ok && avs_address == REG_RSP_HDR;
  assign hi_rd = rd_ok && avs_address == REG_RSP_HI;
  assign lo_rd = rd_ok && avs_address == REG_RSP_LO;
  assign known_op = go_op_q inside {OP_SW_CMD, OP_IN_CMD, OP_TMP_CMD, OP_GRP_CMD};
  assign refused = known_op && go_rw_q != RW_READ;
  assign temp_ok = go_op_q == OP_TMP_CMD && go_rw_q == RW_READ && go_el_q == EL_TEMP;
  assign in_ok = go_op_q == OP_IN_CMD && go_rw_q == RW_READ && go_el_q == EL_INPUT;
  // shadow of the command register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {cmd_el_q, cmd_rw_q, cmd_op_q} <= 18'h00000;
    end else if (wr_ok && avs_address == REG_CMD) begin
      {cmd_el_q, cmd_rw_q, cmd_op_q} <= {avs_writedata[23:16], avs_writedata[9:0]};
    end
  end
  // command captured at go
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {go_el_q, go_rw_q, go_op_q} <= 18'h00000;
    end else if (wr_ok && avs_address == REG_CTRL && avs_writedata[CTRL_GO]) begin
      {go_el_q, go_rw_q, go_op_q} <= {cmd_el_q, cmd_rw_q, cmd_op_q};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence rd_stall;
    avs_read && avs_waitrequest;
  endsequence
  sequence rd_answer;
    avs_read && !avs_waitrequest;
  endsequence
  a_read_answer: assert property ($rose(avs_read) |-> rd_stall ##1 rd_answer)
    else $error("read not answered after one wait");
  a_hdr_opcode: assert property (hdr_rd |-> avs_readdata[7:0] == go_op_q + 8'h01)
    else $error("response opcode wrong");
  a_hdr_echo: assert property (hdr_rd |-> avs_readdata[23:14] == {go_el_q, go_rw_q})
    else $error("element or access not echoed");
  a_write_refused: assert property (hdr_rd && refused |-> avs_readdata[13:8] == ST_NO_WRITE)
    else $error("write form not refused");
  a_refused_data: assert property (hi_rd && refused |-> avs_readdata == 32'h00000000)
    else $error("refused query returned data");
  a_temp_status: assert property (hdr_rd && temp_ok |-> avs_readdata[13:8] == ST_OK)
    else $error("temperature status not ok");
  a_temp_code: assert property (hi_rd && temp_ok |-> avs_readdata == {temp_code, 16'h0000})
    else $error("temperature code wrong");
  a_input_cur: assert property (hi_rd && in_ok |-> avs_readdata == {in_cur_code, in_volt_code[15:8]})
    else $error("input current code wrong");
  a_input_volt: assert property (lo_rd && in_ok |-> avs_readdata[31:16] == {in_volt_code[7:0], 8'h00})
    else $error("input voltage code wrong");
  a_lo_reserved: assert property (lo_rd |-> avs_readdata[15:0] == 16'h0000)
    else $error("reserved reply bits not zero");
endmodule // sqr_top_monitor
bind sqr_top sqr_top_monitor sqr_top_monitor_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .in_cur_code(in_cur_code), .in_volt_code(in_volt_code), .temp_code(temp_code));

// ===== sqr_host.sv
`timescale 1ns/10ps
module sqr_host import sqr_pkg::*; (
  input wire logic        clk_sys,
  output logic      [4:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  // idle bus at time zero
  initial begin
    {avs_address, avs_read, avs_write, avs_writedata} = 39'h0;
    avs_byteenable = 4'hf;
  end
  // one transfer: hold until waitrequest sampled low at a rising edge, take data there,
  // release at that edge and leave one idle edge before the next request
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  // full query: command, go, poll for done, fetch the reply
  task automatic query(input logic [7:0] op, input logic [1:0] rw, input logic [7:0] el,
                       output logic [31:0] hdr, output logic [63:0] dat);
    logic [31:0] d;
    int          n;
    bus(1'b1, REG_CMD, {8'h00, el, 6'h00, rw, op}, d);
    bus(1'b1, REG_CTRL, 32'h00000003, d);
    n = 0;
    do begin
      bus(1'b0, REG_CTRL, 32'h00000000, d);
      n++;
    end while (d[CTRL_DONE] !== 1'b1 && n < 40);
    bus(1'b0, REG_RSP_HDR, 32'h00000000, hdr);
    bus(1'b0, REG_RSP_HI, 32'h00000000, dat[63:32]);
    bus(1'b0, REG_RSP_LO, 32'h00000000, dat[31:0]);
  endtask
endmodule // sqr_host

// ===== status_query_responder_test.sv
`timescale 1ns/10ps
module status_query_responder_test import sqr_pkg::*;;
  logic        clk_sys, rst, ce, avs_read, avs_write, avs_waitrequest, meas_we;
  logic        meas_sw_on, meas_cmd_on, meas_trip, meas_battle;
  logic [4:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [2:0]  meas_chan;
  logic [15:0] meas_out_volt, in_volt_code, temp_code;
  logic [23:0] meas_out_cur, meas_ovl_thr, in_cur_code;
  logic [7:0]  meas_group;
  int          fails, compares;
  sqr_top #(.NUM_CH(8)) sqr_top_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .meas_we(meas_we),
    .meas_chan(meas_chan), .meas_out_volt(meas_out_volt), .meas_out_cur(meas_out_cur),
    .meas_ovl_thr(meas_ovl_thr), .meas_sw_on(meas_sw_on), .meas_cmd_on(meas_cmd_on),
    .meas_trip(meas_trip), .meas_battle(meas_battle), .meas_group(meas_group),
    .in_cur_code(in_cur_code), .in_volt_code(in_volt_code), .temp_code(temp_code));
  sqr_host sqr_host_i (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  // clock
  always #50 clk_sys = ~clk_sys;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one query with header and data judged
  task automatic ask(input logic [7:0] op, input logic [1:0] rw, input logic [7:0] el,
                     input logic [5:0] st, input logic [47:0] dat);
    logic [31:0] hdr;
    logic [63:0] got;
    sqr_host_i.query(op, rw, el, hdr, got);
    check({32'h0, hdr}, {32'h0, 8'h00, el, rw, st, op + 8'h01});
    check(got, {dat, 16'h0000});
  endtask
  // expected switch status data area
  function automatic logic [47:0] swd(input logic [6:0] f, input logic [7:0] g, input logic sh);
    return {1'b0, f[6], 1'b0, f[5], 1'b0, f[4], 1'b0, f[3], 1'b0, f[2], 1'b0, f[1],
            1'b0, f[0], g, 14'h0000, 1'b0, sh, 10'h000};
  endfunction
  // channel record: flags are sw, cmd, trip, battle
  task automatic ld(input logic [2:0] c, input logic [15:0] v, input logic [23:0] i,
                    input logic [3:0] f, input logic [7:0] g);
    meas_we <= 1'b1;
    meas_chan <= c;
    meas_out_volt <= v;
    meas_out_cur <= i;
    {meas_sw_on, meas_cmd_on, meas_trip, meas_battle} <= f;
    meas_group <= g;
    @(posedge clk_sys);
  endtask
  task automatic t_measure;
    ask(OP_TMP_CMD, RW_READ, EL_TEMP, ST_OK, {temp_code, 32'h0});
    ask(OP_IN_CMD, RW_READ, EL_INPUT, ST_OK, {in_cur_code, in_volt_code, 8'h00});
    ask(OP_IN_CMD, RW_READ, EL_TEMP, ST_BAD_ELEM, 48'h0);
    $display("test measure done");
  endtask
  task automatic t_refuse;
    logic [7:0] ops[4] = '{OP_SW_CMD, OP_IN_CMD, OP_TMP_CMD, OP_GRP_CMD};
    logic [7:0] els[4] = '{8'h00, EL_INPUT, EL_TEMP, 8'h67};
    for (int k = 0; k < 8; k++) begin
      ask(ops[k/2], 2'(k % 2 + 1), els[k/2], ST_NO_WRITE, 48'h0);
    end
    $display("test refuse done");
  endtask
  task automatic t_switch;
    ask(OP_SW_CMD, RW_READ, 8'h00, ST_OK, swd(7'b1111001, 8'h03, 1'b1));
    ask(OP_SW_CMD, RW_READ, 8'h01, ST_OK, swd(7'b0001110, GRP_NONE, 1'b0));
    ask(OP_SW_CMD, RW_READ, 8'h02, ST_OK, swd(7'b1101010, 8'h03, 1'b1));
    ask(OP_SW_CMD, RW_READ, 8'h67, ST_OK, swd(7'b1111001, 8'h03, 1'b1));
    ask(OP_SW_CMD, RW_READ, 8'h32, ST_NO_CHAN, 48'h0);
    ask(OP_SW_CMD, RW_READ, 8'h78, ST_NO_GRP, 48'h0);
    $display("test switch done");
  endtask
  // record write while the clock enable is low must not land
  task automatic t_freeze;
    ce <= 1'b0;
    ld(3'h1, V_ZERO + 16'd540, I_ZERO, 4'b1111, 8'h03);
    meas_we <= 1'b0;
    ce <= 1'b1;
    @(posedge clk_sys);
    ask(OP_SW_CMD, RW_READ, 8'h01, ST_OK, swd(7'b0001110, GRP_NONE, 1'b0));
    $display("test freeze done");
  endtask
  task automatic t_group;
    ask(OP_GRP_CMD, RW_READ, 8'h67, ST_OK, {8'h00, 16'h4400, 24'h0});
    ask(OP_GRP_CMD, RW_READ, 8'h68, ST_NO_GRP, 48'h0);
    sqr_host_i.bus(1'b0, 5'h14, 32'h0, d);
    check({32'h0, d}, 64'h0);
    $display("test group done");
  endtask
  // watchdog
  initial begin
    repeat (6000) @(posedge clk_sys);
    fails++;
    report_and_stop();
  end
  // main sequence: 28 V input, 10 A overload threshold
  initial begin
    {clk_sys, rst, ce, meas_we, meas_chan} = {4'b0110, 3'h0};
    {meas_sw_on, meas_cmd_on, meas_trip, meas_battle, meas_group} = 12'h0fb;
    {meas_out_volt, meas_out_cur} = {V_ZERO, I_ZERO};
    meas_ovl_thr = I_ZERO + 24'd1000;
    {in_cur_code, in_volt_code, temp_code} = {I_ZERO + 24'd2500, V_ZERO + 16'd560, 16'h2222};
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    ld(3'h0, V_ZERO + 16'd540, I_ZERO + 24'd500, 4'b1101, 8'h03);
    ld(3'h1, V_ZERO + 16'd10, I_ZERO + 24'd500, 4'b0010, GRP_NONE);
    ld(3'h2, V_ZERO + 16'd100, I_ZERO + 24'd600, 4'b1100, 8'h03);
    for (int c = 3; c < 8; c++) ld(3'(c), V_ZERO, I_ZERO, 4'b0000, GRP_NONE);
    meas_we <= 1'b0;
    @(posedge clk_sys);
    t_measure();
    t_refuse();
    t_switch();
    t_freeze();
    t_group();
    report_and_stop();
  end
endmodule // status_query_responder_test
